// >>> tb/rbf_checker.sv
module rbf_checker
    import rbf_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [11:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [15:0] rdata
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    // ------------------------------------------------------------
    // Reference of the running transfer, rebuilt from bus traffic
    // ------------------------------------------------------------
    logic [7:0] op_r;
    logic fmt_r;
    logic ph_r;
    logic act_r;
    logic act_nxt;
    logic stq_r;
    logic start_wr;
    logic start_ok;
    logic pop;
    logic [15:0] w_r;
    logic [15:0] h_r;
    logic [3:0] since_r;
    logic [31:0] cnt_r;
    logic [31:0] words;
    assign start_wr = wr && addr == BLIT_CONTROL_STATUS && wdata[7:0] == START_CMD;
    assign start_ok = start_wr && op_r == OP_READ_BLIT && !act_r;
    assign pop = rd && addr == BLIT_FIFO_PORT && act_r;
    assign words = fmt_r ? (32'(w_r) + 1) * (32'(h_r) + 1) : ((32'(w_r) + 2 + 32'(ph_r)) >> 1) * (32'(h_r) + 1);
    always_comb begin
        act_nxt = act_r;
        if (start_ok) begin
            act_nxt = 1'b1;
        end else if (pop && cnt_r + 1 >= words) begin
            act_nxt = 1'b0;
        end
    end
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            op_r <= REG_RESET;
            fmt_r <= 1'b0;
            ph_r <= 1'b0;
            w_r <= '0;
            h_r <= '0;
        end else if (wr) begin
            case (addr)
                BLIT_OPERATION_SELECT: op_r <= wdata[7:0];
                BLIT_PIXEL_FORMAT: fmt_r <= wdata[7:0] != FMT_BYTE_PIXELS;
                BLIT_DEST_ADDR_LOW: ph_r <= wdata[BIT_PHASE];
                BLIT_WIDTH_LOW: w_r[7:0] <= wdata[7:0];
                BLIT_WIDTH_HIGH: w_r[15:8] <= wdata[7:0];
                BLIT_HEIGHT_LOW: h_r[7:0] <= wdata[7:0];
                BLIT_HEIGHT_HIGH: h_r[15:8] <= wdata[7:0];
                default: ;
            endcase
        end
    end
    // Settle time is counted so status is judged only once the two-cycle lag is over
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            act_r <= 1'b0;
            cnt_r <= '0;
            since_r <= '0;
            stq_r <= 1'b0;
        end else begin
            act_r <= act_nxt;
            cnt_r <= start_ok ? '0 : cnt_r + 32'(pop);
            since_r <= (act_nxt != act_r) ? '0 : since_r + 4'(since_r != 4'hf);
            stq_r <= rd && addr == BLIT_CONTROL_STATUS;
        end
    end
    AST_RDATA_QUIET: assert property (!$past(rd) |-> rdata == 16'h0000)
        else $error("read data outside answer cycle");
    AST_WR_RD_EXCL: assert property (!(wr && rd))
        else $error("write and read strobes together");
    AST_STATUS_NESTED: assert property (stq_r |-> (!rdata[BIT_FULL] || rdata[BIT_HALF])
        && (!rdata[BIT_HALF] || rdata[BIT_NOT_EMPTY]))
        else $error("fill flags inconsistent");
    AST_ACTIVE_HELD: assert property (stq_r && $past(act_r) && $past(since_r) >= 4'd2 |-> rdata[BIT_ACTIVE])
        else $error("active dropped before last word");
    AST_ACTIVE_CLEARS: assert property (stq_r && !$past(act_r) && $past(since_r) >= 4'd3 |-> !rdata[BIT_ACTIVE])
        else $error("active stuck after last word");
    AST_EMPTY_IDLE: assert property (stq_r && !$past(act_r) && $past(since_r) >= 4'd3 |-> !rdata[BIT_NOT_EMPTY])
        else $error("words left after transfer");
    AST_START_IDLE: assert property (start_wr |-> !act_r)
        else $error("start while active");
    AST_START_OP: assert property (start_wr |-> op_r == OP_READ_BLIT)
        else $error("start without read mode");
    AST_POP_ACTIVE: assert property (rd && addr == BLIT_FIFO_PORT |-> act_r)
        else $error("fifo read outside transfer");
endmodule // rbf_checker

// >>> tb/read_blit_fifo_engine_tb.sv
`define CHK(g, e) begin \
    tests_run++; \
    if ((g) !== (e)) begin \
        mismatches++; \
        $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
end
module read_blit_fifo_engine_tb
    import rbf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [11:0] REGS [12] = '{BLIT_OPERATION_SELECT, BLIT_PIXEL_FORMAT, BLIT_SOURCE_ADDR_LOW,
        BLIT_SOURCE_ADDR_MID, BLIT_SOURCE_ADDR_HIGH, BLIT_DEST_ADDR_LOW, BLIT_LINE_STRIDE_LOW,
        BLIT_LINE_STRIDE_HIGH, BLIT_WIDTH_LOW, BLIT_WIDTH_HIGH, BLIT_HEIGHT_LOW, BLIT_HEIGHT_HIGH};
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    int mismatches = 0;
    int tests_run = 0;
    logic [20:0] ma_addr;
    logic [20:0] mb_addr;
    logic ma_rd;
    logic mb_rd;
    logic [7:0] ma_data = 8'h00;
    logic [7:0] mb_data = 8'h00;
    logic act_a;
    logic act_b;
    logic go = 1'b0;
    logic [23:0] src = '0;
    logic [15:0] wm1 = '0;
    logic [15:0] hm1 = '0;
    logic [15:0] stride = '0;
    logic bpx = 1'b0;
    logic ph = 1'b0;
    logic busy;
    logic ovalid;
    logic [15:0] oword;
    logic [15:0] d;
    logic [15:0] got_q[$];
    logic [15:0] exp_q[$];
    logic [15:0] msk_q[$];
    logic [7:0] vals[12];
    logic [7:0] v;
    logic [23:0] s;
    rbf_bus_if bus_a ();
    rbf_bus_if bus_b ();
    always #50 ref_clk = ~ref_clk;
    rbf_engine i_rbf_engine (.ref_clk(ref_clk), .reset(reset), .bus(bus_a), .mem_addr(ma_addr),
        .mem_rd(ma_rd), .mem_data(ma_data), .blit_active(act_a));
    rbf_host i_rbf_host (.ref_clk(ref_clk), .reset(reset), .bus(bus_a), .cmd_go(go), .cmd_src(src),
        .cmd_width_m1(wm1), .cmd_height_m1(hm1), .cmd_stride(stride), .cmd_byte_pixels(bpx),
        .cmd_phase(ph), .busy(busy), .out_word(oword), .out_valid(ovalid));
    rbf_checker i_rbf_checker (.ref_clk(ref_clk), .reset(reset), .addr(bus_a.addr), .wdata(bus_a.wdata),
        .wr(bus_a.wr), .rd(bus_a.rd), .rdata(bus_a.rdata));
    // Second engine, driven directly so refusals and fill limits can be provoked
    rbf_engine i_rbf_engine_b (.ref_clk(ref_clk), .reset(reset), .bus(bus_b), .mem_addr(mb_addr),
        .mem_rd(mb_rd), .mem_data(mb_data), .blit_active(act_b));
    // ------------------------------------------------------------
    // Display buffer models and expectation
    // ------------------------------------------------------------
    function automatic logic [7:0] pix(logic [20:0] a);
        return a[7:0] ^ {a[11:8], a[15:12]} ^ a[20:13];
    endfunction
    // Idle cycles show the inverse of the last byte so a late sample cannot match by luck
    always @(posedge ref_clk) begin
        ma_data <= ma_rd ? pix(ma_addr) : ~ma_data;
        mb_data <= mb_rd ? pix(mb_addr) : ~mb_data;
        if (ovalid === 1'b1) got_q.push_back(oword);
    end
    // Word pixels are treated as two byte lanes with no phase offset
    function automatic void build(logic [23:0] sa, int w1, int h1, int st, bit bp, int p);
        logic [20:0] base;
        logic [15:0] e;
        logic [15:0] m;
        int lo;
        int nb;
        int pp;
        exp_q.delete();
        msk_q.delete();
        nb = bp ? w1 : 2 * w1 + 1;
        pp = bp ? p : 0;
        for (int y = 0; y <= h1; y++) begin
            base = sa[20:0] + 21'(y * st * 2);
            for (int j = 0; j < (nb + 2 + pp) / 2; j++) begin
                lo = 2 * j - pp;
                e = '0;
                m = '0;
                if (lo >= 0) begin
                    e[7:0] = pix(base + 21'(lo));
                    m[7:0] = 8'hff;
                end
                if (lo + 1 <= nb) begin
                    e[15:8] = pix(base + 21'(lo + 1));
                    m[15:8] = 8'hff;
                end
                exp_q.push_back(e);
                msk_q.push_back(m);
            end
        end
    endfunction
    task automatic test_done();
        if (mismatches == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic run_host(logic [23:0] sa, int w1, int h1, int st, bit bp, bit p);
        int k;
        build(sa, w1, h1, st, bp, p);
        @(posedge ref_clk);
        got_q.delete();
        src <= sa;
        wm1 <= 16'(w1);
        hm1 <= 16'(h1);
        stride <= 16'(st);
        bpx <= bp;
        ph <= p;
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        for (k = 0; k < 4 && busy !== 1'b1; k++) @(posedge ref_clk);
        for (k = 0; k < 30000 && busy !== 1'b0; k++) @(posedge ref_clk);
        if (busy !== 1'b0) begin
            mismatches++;
            test_done();
        end
        repeat (2) @(posedge ref_clk);
        `CHK(got_q.size(), exp_q.size())
        foreach (exp_q[i]) if (i < got_q.size()) `CHK(got_q[i] & msk_q[i], exp_q[i])
        `CHK(act_a, 1'b0)
    endtask
    task automatic wr_b(logic [11:0] a, logic [7:0] dv);
        @(posedge ref_clk);
        bus_b.addr <= a;
        bus_b.wdata <= {8'h00, dv};
        bus_b.wr <= 1'b1;
        @(posedge ref_clk);
        bus_b.wr <= 1'b0;
    endtask
    task automatic rd_b(logic [11:0] a);
        @(posedge ref_clk);
        bus_b.addr <= a;
        bus_b.rd <= 1'b1;
        @(posedge ref_clk);
        bus_b.rd <= 1'b0;
        #1 d = bus_b.rdata;
    endtask
    task automatic poll_b(int b);
        int k;
        for (k = 0; k < 2000 && d[b] !== 1'b1; k++) rd_b(BLIT_CONTROL_STATUS);
        if (d[b] !== 1'b1) begin
            mismatches++;
            test_done();
        end
    endtask
    initial begin
        bus_b.addr = '0;
        bus_b.wdata = '0;
        bus_b.wr = 1'b0;
        bus_b.rd = 1'b0;
        void'($urandom(32'hb4a21154));
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        run_host(24'h000100, 0, 0, 16, 1, 1);
        run_host(24'h000232, 1, 2, 32, 1, 1);
        run_host(24'h001000, 2, 1, 4, 1, 0);
        run_host(24'h002000, 0, 0, 8, 0, 0);
        repeat (6) run_host({4'h0, 20'($urandom)} & 24'hfffffe, $urandom_range(40), $urandom_range(4),
            $urandom_range(64), 1'($urandom), 1'($urandom));
        foreach (REGS[i]) begin
            rd_b(REGS[i]);
            `CHK(d, {8'h00, REG_RESET})
        end
        rd_b(12'h102);
        `CHK(d, 16'h0000)
        foreach (REGS[i]) begin
            v = 8'($urandom);
            wr_b(REGS[i], v);
            rd_b(REGS[i]);
            `CHK(d, {8'h00, v})
        end
        wr_b(BLIT_OPERATION_SELECT, 8'h02);
        wr_b(BLIT_CONTROL_STATUS, START_CMD);
        rd_b(BLIT_CONTROL_STATUS);
        `CHK(d[BIT_ACTIVE], 1'b0)
        s = {4'h0, 20'($urandom)} & 24'hfffffe;
        vals = '{OP_READ_BLIT, 8'h01, s[7:0], s[15:8], s[23:16], 8'h00, 8'h20, 8'h00, 8'h27, 8'h00, 8'h01, 8'h00};
        foreach (REGS[i]) wr_b(REGS[i], vals[i]);
        build(s, 39, 1, 32, 0, 0);
        wr_b(BLIT_CONTROL_STATUS, START_CMD);
        rd_b(BLIT_CONTROL_STATUS);
        `CHK(d[BIT_ACTIVE], 1'b1)
        wr_b(BLIT_WIDTH_LOW, 8'h03);
        poll_b(BIT_FULL);
        repeat (20) @(posedge ref_clk);
        rd_b(BLIT_CONTROL_STATUS);
        `CHK(d[7:4], 4'hf)
        // A full FIFO allows sixteen reads with no status check in between
        foreach (exp_q[i]) begin
            if (i >= FIFO_DEPTH) begin
                d = '0;
                poll_b(BIT_NOT_EMPTY);
                `CHK(d[BIT_ACTIVE], 1'b1)
            end
            rd_b(BLIT_FIFO_PORT);
            `CHK(d & msk_q[i], exp_q[i])
        end
        repeat (3) @(posedge ref_clk);
        rd_b(BLIT_CONTROL_STATUS);
        `CHK(d[7:4], 4'h0)
        `CHK(act_b, 1'b0)
        rd_b(BLIT_FIFO_PORT);
        `CHK(d, 16'h0000)
        test_done();
    end
endmodule // read_blit_fifo_engine_tb

// >>> verilog/rbf_bus_if.sv
interface rbf_bus_if;
    logic [11:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
    logic [15:0] rdata;
    modport dev (input addr, input wdata, input wr, input rd, output rdata);
    modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface : rbf_bus_if

// >>> verilog/rbf_engine.sv
module rbf_engine
    import rbf_pkg::*;
#(
    parameter int MEM_AW = 21
) (
    input wire logic ref_clk,
    input wire logic reset,
    rbf_bus_if.dev bus,
    // Display buffer byte read port, data one cycle after address
    output logic [MEM_AW-1:0] mem_addr,
    output logic mem_rd,
    input wire logic [7:0] mem_data,
    output logic blit_active
);
    initial begin
        if (MEM_AW < 17 || MEM_AW > 24) $error("MEM_AW out of range");
    end

    typedef enum {S_IDLE, S_FETCH, S_WAIT, S_DRAIN} rbf_state_t;

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    logic [7:0] fmt_r, op_r, dst_r;
    logic [23:0] src_r;
    logic [15:0] stride_r, width_r, height_r;
    logic start;
    assign start = bus.wr && bus.addr == BLIT_CONTROL_STATUS && bus.wdata[7:0] == START_CMD
        && !blit_active && op_r == OP_READ_BLIT;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            fmt_r <= REG_RESET;
            op_r <= REG_RESET;
            dst_r <= REG_RESET;
            src_r <= '0;
            stride_r <= '0;
            width_r <= '0;
            height_r <= '0;
        end else if (bus.wr) begin
            case (bus.addr)
                BLIT_PIXEL_FORMAT: fmt_r <= bus.wdata[7:0];
                BLIT_OPERATION_SELECT: op_r <= bus.wdata[7:0];
                BLIT_DEST_ADDR_LOW: dst_r <= bus.wdata[7:0];
                BLIT_SOURCE_ADDR_LOW: src_r[7:0] <= bus.wdata[7:0];
                BLIT_SOURCE_ADDR_MID: src_r[15:8] <= bus.wdata[7:0];
                BLIT_SOURCE_ADDR_HIGH: src_r[23:16] <= bus.wdata[7:0];
                BLIT_LINE_STRIDE_LOW: stride_r[7:0] <= bus.wdata[7:0];
                BLIT_LINE_STRIDE_HIGH: stride_r[15:8] <= bus.wdata[7:0];
                BLIT_WIDTH_LOW: width_r[7:0] <= bus.wdata[7:0];
                BLIT_WIDTH_HIGH: width_r[15:8] <= bus.wdata[7:0];
                BLIT_HEIGHT_LOW: height_r[7:0] <= bus.wdata[7:0];
                BLIT_HEIGHT_HIGH: height_r[15:8] <= bus.wdata[7:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Working copy, taken only at start
    // ----------------------------------------------------------------
    rbf_state_t state_r;
    logic byte_mode_r, phase_r;
    logic [16:0] npix_r, nlines_r, pix_r, line_r;
    logic [16:0] words_left_r;
    logic [MEM_AW-1:0] line_base_r, rd_addr_r;
    logic [16:0] stride_bytes_r;
    logic hi_r; // next byte goes to the high lane
    logic [7:0] lo_byte_r;
    logic pend_r, eol_q_r, pend_eol_r;

    // FIFO
    logic [15:0] fifo_mem [FIFO_DEPTH];
    logic [3:0] wp_r, rp_r;
    logic [4:0] cnt_r;
    logic push;
    logic [15:0] push_data;
    logic pop;
    assign pop = bus.rd && bus.addr == BLIT_FIFO_PORT && cnt_r != 5'h00;

    function automatic logic [16:0] words_per_line(input logic bm, input logic ph, input logic [16:0] w);
        words_per_line = bm ? 17'((w + 17'h1 + 17'(ph)) >> 1) : w;
    endfunction

    // Room for the word that an in-flight byte may complete
    logic room;
    assign room = cnt_r + 5'(mem_rd) + 5'(pend_r) < 5'(FIFO_DEPTH);

    // ----------------------------------------------------------------
    // Fetch sequencer
    // ----------------------------------------------------------------
    logic fetch, sub_r, step;
    logic last_pix, eol;
    assign fetch = state_r == S_FETCH && room;
    assign step = byte_mode_r || sub_r;
    assign eol = pix_r == npix_r - 17'h1;
    assign last_pix = eol && line_r == nlines_r - 17'h1;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_r <= S_IDLE;
            byte_mode_r <= 1'b0;
            phase_r <= 1'b0;
            npix_r <= '0;
            nlines_r <= '0;
            pix_r <= '0;
            line_r <= '0;
            line_base_r <= '0;
            rd_addr_r <= '0;
            stride_bytes_r <= '0;
            words_left_r <= '0;
        end else begin
            case (state_r)
                S_IDLE: if (start) begin
                    byte_mode_r <= fmt_r == FMT_BYTE_PIXELS;
                    phase_r <= dst_r[BIT_PHASE];
                    npix_r <= {1'b0, width_r} + 17'h1;
                    nlines_r <= {1'b0, height_r} + 17'h1;
                    words_left_r <= 17'(words_per_line(fmt_r == FMT_BYTE_PIXELS, dst_r[BIT_PHASE],
                        {1'b0, width_r} + 17'h1) * ({1'b0, height_r} + 17'h1));
                    line_base_r <= src_r[MEM_AW-1:0];
                    rd_addr_r <= src_r[MEM_AW-1:0];
                    stride_bytes_r <= {stride_r, 1'b0};
                    pix_r <= '0;
                    line_r <= '0;
                    state_r <= S_FETCH;
                end
                S_FETCH: if (fetch && step) begin
                    if (last_pix) begin
                        state_r <= S_DRAIN;
                    end else if (eol) begin
                        pix_r <= '0;
                        line_r <= line_r + 17'h1;
                        line_base_r <= line_base_r + MEM_AW'(stride_bytes_r);
                        rd_addr_r <= line_base_r + MEM_AW'(stride_bytes_r);
                    end else begin
                        pix_r <= pix_r + 17'h1;
                        rd_addr_r <= rd_addr_r + (byte_mode_r ? MEM_AW'(1) : MEM_AW'(2));
                    end
                end
                S_DRAIN: if (words_left_r == '0 && !pend_r) state_r <= S_IDLE;
                default: state_r <= S_IDLE;
            endcase
            if (pop) words_left_r <= words_left_r - 17'h1;
        end
    end

    // A 16 bpp pixel is fetched as two bytes; simplest is two reads per pixel
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sub_r <= 1'b0;
            mem_rd <= 1'b0;
            mem_addr <= '0;
            pend_r <= 1'b0;
            eol_q_r <= 1'b0;
            pend_eol_r <= 1'b0;
        end else begin
            mem_rd <= fetch;
            mem_addr <= byte_mode_r ? rd_addr_r : rd_addr_r + MEM_AW'(sub_r);
            eol_q_r <= eol && step;
            pend_r <= mem_rd;
            pend_eol_r <= eol_q_r;
            if (fetch && !byte_mode_r) sub_r <= ~sub_r;
        end
    end

    // Byte packer: in 8 bpp a pixel lands in lane hi_r, words push when high lane filled or line ends
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            hi_r <= 1'b0;
            lo_byte_r <= 8'h00;
        end else if (start) begin
            hi_r <= fmt_r == FMT_BYTE_PIXELS && dst_r[BIT_PHASE];
            lo_byte_r <= 8'h00;
        end else if (pend_r) begin
            if (pend_eol_r) begin
                hi_r <= byte_mode_r && phase_r;
                lo_byte_r <= 8'h00;
            end else if (!hi_r) begin
                lo_byte_r <= mem_data;
                hi_r <= 1'b1;
            end else begin
                hi_r <= 1'b0;
            end
        end
    end
    // A lone line-end pixel pushes with a zero high byte
    assign push = pend_r && (hi_r || pend_eol_r);
    assign push_data = hi_r ? {mem_data, lo_byte_r} : {8'h00, mem_data};

    // ----------------------------------------------------------------
    // Output FIFO
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (push) fifo_mem[wp_r] <= push_data;
    end
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) wp_r <= wp_r + 4'h1;
            if (pop) rp_r <= rp_r + 4'h1;
            cnt_r <= cnt_r + 5'(push) - 5'(pop);
        end
    end

    // ----------------------------------------------------------------
    // Read port and status
    // ----------------------------------------------------------------
    logic [7:0] status;
    always_comb begin
        status = 8'h00;
        status[BIT_ACTIVE] = state_r != S_IDLE;
        status[BIT_FULL] = cnt_r == 5'(FIFO_DEPTH);
        status[BIT_HALF] = cnt_r >= 5'(FIFO_HALF);
        status[BIT_NOT_EMPTY] = cnt_r != 5'h00;
    end
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            bus.rdata <= '0;
            blit_active <= 1'b0;
        end else begin
            blit_active <= state_r != S_IDLE;
            bus.rdata <= '0;
            if (bus.rd) begin
                case (bus.addr)
                    BLIT_CONTROL_STATUS: bus.rdata <= {8'h00, status};
                    BLIT_PIXEL_FORMAT: bus.rdata <= {8'h00, fmt_r};
                    BLIT_OPERATION_SELECT: bus.rdata <= {8'h00, op_r};
                    BLIT_DEST_ADDR_LOW: bus.rdata <= {8'h00, dst_r};
                    BLIT_SOURCE_ADDR_LOW: bus.rdata <= {8'h00, src_r[7:0]};
                    BLIT_SOURCE_ADDR_MID: bus.rdata <= {8'h00, src_r[15:8]};
                    BLIT_SOURCE_ADDR_HIGH: bus.rdata <= {8'h00, src_r[23:16]};
                    BLIT_LINE_STRIDE_LOW: bus.rdata <= {8'h00, stride_r[7:0]};
                    BLIT_LINE_STRIDE_HIGH: bus.rdata <= {8'h00, stride_r[15:8]};
                    BLIT_WIDTH_LOW: bus.rdata <= {8'h00, width_r[7:0]};
                    BLIT_WIDTH_HIGH: bus.rdata <= {8'h00, width_r[15:8]};
                    BLIT_HEIGHT_LOW: bus.rdata <= {8'h00, height_r[7:0]};
                    BLIT_HEIGHT_HIGH: bus.rdata <= {8'h00, height_r[15:8]};
                    BLIT_FIFO_PORT: bus.rdata <= (cnt_r != 5'h00) ? fifo_mem[rp_r] : 16'h0000;
                    default: bus.rdata <= '0;
                endcase
            end
        end
    end
endmodule : rbf_engine

// >>> verilog/rbf_host.sv
// Host end: programs a read blit from a command port and drains the FIFO into a word stream.
module rbf_host
    import rbf_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    rbf_bus_if.host bus,
    input wire logic cmd_go,
    input wire logic [23:0] cmd_src,
    input wire logic [15:0] cmd_width_m1,
    input wire logic [15:0] cmd_height_m1,
    input wire logic [15:0] cmd_stride,
    input wire logic cmd_byte_pixels,
    input wire logic cmd_phase,
    output logic busy,
    output logic [15:0] out_word,
    output logic out_valid
);
    typedef enum {H_IDLE, H_WAIT_IDLE, H_PROG, H_WAIT_ACT, H_POLL, H_STAT, H_READ, H_DONE} rbf_hstate_t;
    rbf_hstate_t st_r;
    logic [3:0] idx_r;
    logic [4:0] burst_r;
    logic rd_pend_r, rd_fifo_r;
    logic [7:0] val;
    logic [11:0] adr;

    // Program sequence; start command goes last
    always_comb begin
        case (idx_r)
            4'h0: begin adr = BLIT_PIXEL_FORMAT; val = cmd_byte_pixels ? FMT_BYTE_PIXELS : 8'h01; end
            4'h1: begin adr = BLIT_OPERATION_SELECT; val = OP_READ_BLIT; end
            4'h2: begin adr = BLIT_SOURCE_ADDR_LOW; val = cmd_src[7:0]; end
            4'h3: begin adr = BLIT_SOURCE_ADDR_MID; val = cmd_src[15:8]; end
            4'h4: begin adr = BLIT_SOURCE_ADDR_HIGH; val = cmd_src[23:16]; end
            4'h5: begin adr = BLIT_DEST_ADDR_LOW; val = {7'h00, cmd_phase}; end
            4'h6: begin adr = BLIT_LINE_STRIDE_LOW; val = cmd_stride[7:0]; end
            4'h7: begin adr = BLIT_LINE_STRIDE_HIGH; val = cmd_stride[15:8]; end
            4'h8: begin adr = BLIT_WIDTH_LOW; val = cmd_width_m1[7:0]; end
            4'h9: begin adr = BLIT_WIDTH_HIGH; val = cmd_width_m1[15:8]; end
            4'ha: begin adr = BLIT_HEIGHT_LOW; val = cmd_height_m1[7:0]; end
            4'hb: begin adr = BLIT_HEIGHT_HIGH; val = cmd_height_m1[15:8]; end
            default: begin adr = BLIT_CONTROL_STATUS; val = START_CMD; end
        endcase
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            st_r <= H_IDLE;
            idx_r <= '0;
            burst_r <= '0;
            rd_pend_r <= 1'b0;
            rd_fifo_r <= 1'b0;
            bus.addr <= '0;
            bus.wdata <= '0;
            bus.wr <= 1'b0;
            bus.rd <= 1'b0;
            busy <= 1'b0;
            out_word <= '0;
            out_valid <= 1'b0;
        end else begin
            bus.wr <= 1'b0;
            bus.rd <= 1'b0;
            out_valid <= 1'b0;
            rd_pend_r <= bus.rd;
            rd_fifo_r <= bus.rd && bus.addr == BLIT_FIFO_PORT;
            if (rd_fifo_r) begin // word-wide FIFO reads only
                out_word <= bus.rdata;
                out_valid <= 1'b1;
            end
            case (st_r)
                H_IDLE: if (cmd_go) begin
                    busy <= 1'b1;
                    st_r <= H_WAIT_IDLE;
                end
                H_WAIT_IDLE: if (!bus.rd && !rd_pend_r) begin
                    bus.rd <= 1'b1;
                    bus.addr <= BLIT_CONTROL_STATUS;
                end else if (rd_pend_r && !bus.rdata[BIT_ACTIVE]) begin
                    idx_r <= '0;
                    st_r <= H_PROG;
                end
                H_PROG: begin
                    bus.wr <= 1'b1;
                    bus.addr <= adr;
                    bus.wdata <= {8'h00, val};
                    idx_r <= idx_r + 4'h1;
                    if (idx_r == 4'hc) st_r <= H_WAIT_ACT;
                end
                H_WAIT_ACT, H_POLL: if (!bus.rd && !rd_pend_r) begin
                    bus.rd <= 1'b1;
                    bus.addr <= BLIT_CONTROL_STATUS;
                end else if (rd_pend_r && !rd_fifo_r) begin
                    if (st_r == H_WAIT_ACT) begin
                        if (bus.rdata[BIT_ACTIVE]) st_r <= H_POLL;
                    end else if (!bus.rdata[BIT_ACTIVE]) begin
                        st_r <= H_DONE;
                    end else if (bus.rdata[BIT_FULL]) begin
                        burst_r <= 5'(FIFO_DEPTH);
                        st_r <= H_READ;
                    end else if (bus.rdata[BIT_HALF]) begin
                        burst_r <= 5'(FIFO_HALF);
                        st_r <= H_READ;
                    end else if (bus.rdata[BIT_NOT_EMPTY]) begin
                        burst_r <= 5'h01;
                        st_r <= H_READ;
                    end
                end
                H_READ: begin
                    bus.rd <= 1'b1;
                    bus.addr <= BLIT_FIFO_PORT;
                    burst_r <= burst_r - 5'h01;
                    if (burst_r == 5'h01) st_r <= H_STAT;
                end
                H_STAT: st_r <= H_POLL;
                H_DONE: begin
                    busy <= 1'b0;
                    st_r <= H_IDLE;
                end
                default: st_r <= H_IDLE;
            endcase
        end
    end
endmodule : rbf_host

// >>> verilog/rbf_pkg.sv
package rbf_pkg;
    // ----------------------------------------------------------------
    // Register map (byte offsets, 8-bit registers)
    // ----------------------------------------------------------------
    localparam logic [11:0] BLIT_CONTROL_STATUS = 12'h100;
    localparam logic [11:0] BLIT_PIXEL_FORMAT = 12'h101;
    localparam logic [11:0] BLIT_OPERATION_SELECT = 12'h103;
    localparam logic [11:0] BLIT_SOURCE_ADDR_LOW = 12'h104;
    localparam logic [11:0] BLIT_SOURCE_ADDR_MID = 12'h105;
    localparam logic [11:0] BLIT_SOURCE_ADDR_HIGH = 12'h106;
    localparam logic [11:0] BLIT_DEST_ADDR_LOW = 12'h108;
    localparam logic [11:0] BLIT_LINE_STRIDE_LOW = 12'h10c;
    localparam logic [11:0] BLIT_LINE_STRIDE_HIGH = 12'h10d;
    localparam logic [11:0] BLIT_WIDTH_LOW = 12'h110;
    localparam logic [11:0] BLIT_WIDTH_HIGH = 12'h111;
    localparam logic [11:0] BLIT_HEIGHT_LOW = 12'h112;
    localparam logic [11:0] BLIT_HEIGHT_HIGH = 12'h113;
    // FIFO data port of the transfer path, word wide
    localparam logic [11:0] BLIT_FIFO_PORT = 12'h400;
    // ----------------------------------------------------------------
    // Fields and values
    // ----------------------------------------------------------------
    localparam int BIT_ACTIVE = 7;
    localparam int BIT_FULL = 6;
    localparam int BIT_HALF = 5;
    localparam int BIT_NOT_EMPTY = 4;
    localparam int BIT_PHASE = 0;
    localparam logic [7:0] START_CMD = 8'h80;
    localparam logic [7:0] OP_READ_BLIT = 8'h01;
    localparam logic [7:0] FMT_BYTE_PIXELS = 8'h00;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_HALF = 8;
endpackage : rbf_pkg
